//--- rtl/rap_regs.svh
// Purpose: Constants for the return address predictor.
// Assumes: 32-bit addresses, one clock, synchronous active-high reset.
// Notes:   Offsets are absent; the block has no software registers.
`ifndef RAP_REGS_SVH
`define RAP_REGS_SVH
`define RAP_DEPTH       3
`define RAP_PTR_W       2
`define RAP_ADDR_W      32
`define RAP_LINK_REG    4'hE
`define RAP_FLOW_EN_BIT 11
`define RAP_CTRL_W      12
`define RAP_CTRL_RESET  12'h000
`define RAP_ADDR_RESET  32'h00000000
`endif

//--- rtl/rap_pkg.sv
// Purpose: Types for the return address predictor.
// Assumes: Decode supplies a classified instruction kind.
// Notes:   Kind encoding is arbitrary but fixed here.
package rap_pkg;
   typedef enum logic [2:0] {
      RAP_KIND_OTHER      = 3'h0,
      RAP_KIND_CALL_IMM   = 3'h1,  // call_imm immediate
      RAP_KIND_CALL_XIMM  = 3'h2,  // call_exchange immediate
      RAP_KIND_CALL_XREG  = 3'h3,  // call_exchange register
      RAP_KIND_RET_LINK   = 3'h4,  // branch_exchange register
      RAP_KIND_RET_MULTI  = 3'h5,  // load_multiple from sp with writeback
      RAP_KIND_RET_LDW    = 3'h6   // load_word to pc from sp
   } rap_kind_t;
endpackage

//--- rtl/rap_return_predictor.sv
// Purpose: Return-address stack with call/return recognition and recovery.
// Assumes: Fetch inputs and execute inputs are on the core clock.
// Notes:   Predictions are combinational; stack state is registered.
//          Only the most recent popped address is compared at resolution,
//          so a return resolved after a second pop is compared with that pop's address.
`timescale 1ns/1ps
`include "rap_regs.svh"
module rap_return_predictor (
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   // Control bits
   input  wire logic [`RAP_CTRL_W-1:0] ctrl_in,
   input  wire logic                   stack_enable_in,
   // Fetch-side decode
   input  wire logic                   fetch_valid_in,
   input  wire rap_pkg::rap_kind_t     fetch_kind_in,
   input  wire logic [3:0]             fetch_reg_in,
   input  wire logic                   fetch_pc_wb_in,
   input  wire logic                   fetch_cond_in,
   input  wire logic                   target_hit_in,
   // Execute-side resolution
   input  wire logic                   ex_push_in,
   input  wire logic [`RAP_ADDR_W-1:0] ex_ret_addr_in,
   input  wire logic                   ex_ret_valid_in,
   input  wire logic                   ex_cond_pass_in,
   input  wire logic [`RAP_ADDR_W-1:0] ex_actual_addr_in,
   input  wire logic [`RAP_ADDR_W-1:0] ex_recovery_addr_in,
   // Prediction outputs
   output logic                        call_predict_out,
   output logic                        call_taken_out,
   output logic                        ret_predict_out,
   output logic [`RAP_ADDR_W-1:0]      ret_target_out,
   // Recovery outputs and stack count
   output logic                        flush_out,
   output logic [`RAP_ADDR_W-1:0]      refetch_addr_out,
   output logic [`RAP_PTR_W-1:0]       count_out
);
   logic [`RAP_ADDR_W-1:0] stack_reg [`RAP_DEPTH];
   logic [`RAP_ADDR_W-1:0] stack_next [`RAP_DEPTH];
   logic [`RAP_PTR_W-1:0]  top_reg, top_next;
   logic [`RAP_PTR_W-1:0]  cnt_reg, cnt_next;
   logic [`RAP_ADDR_W-1:0] pred_reg, pred_next;
   logic                   pend_reg, pend_next;
   logic                   flush_reg, flush_next;
   logic [`RAP_ADDR_W-1:0] refetch_reg, refetch_next;
   logic                   enabled, is_call, is_ret, pop, mispredict;

   // Circular pointer step, kept inside the three slots
   function automatic logic [`RAP_PTR_W-1:0] ptr_inc(input logic [`RAP_PTR_W-1:0] p);
      ptr_inc = (p == `RAP_PTR_W'(`RAP_DEPTH - 1)) ? `RAP_PTR_W'(0)
                                                   : p + `RAP_PTR_W'(1);
   endfunction
   function automatic logic [`RAP_PTR_W-1:0] ptr_dec(input logic [`RAP_PTR_W-1:0] p);
      ptr_dec = (p == `RAP_PTR_W'(0)) ? `RAP_PTR_W'(`RAP_DEPTH - 1) : p - `RAP_PTR_W'(1);
   endfunction

   // Recognition of calls and returns
   always_comb begin
      enabled = ctrl_in[`RAP_FLOW_EN_BIT];
      is_call = (fetch_kind_in == rap_pkg::RAP_KIND_CALL_IMM)
             || (fetch_kind_in == rap_pkg::RAP_KIND_CALL_XIMM);
      is_ret  = ((fetch_kind_in == rap_pkg::RAP_KIND_RET_LINK) && (fetch_reg_in == `RAP_LINK_REG))
             || ((fetch_kind_in == rap_pkg::RAP_KIND_RET_MULTI) && fetch_pc_wb_in)
             || (fetch_kind_in == rap_pkg::RAP_KIND_RET_LDW);
   end

   // Predictions; register-form call is left out of is_call and never predicted
   always_comb begin
      call_predict_out = enabled && fetch_valid_in && is_call;
      call_taken_out   = call_predict_out && (target_hit_in || !fetch_cond_in);
      // Only always-taken (unconditional) returns, non-empty stack
      ret_predict_out  = enabled && stack_enable_in && fetch_valid_in && is_ret
                      && !fetch_cond_in
                      && (cnt_reg != `RAP_PTR_W'(0));
      ret_target_out   = stack_reg[top_reg];
      pop              = ret_predict_out;
   end

   // Stack next state; push of a register call also counts as a call
   // A full push steps the pointer onto the oldest slot, which is lost
   always_comb begin
      stack_next = stack_reg;
      top_next   = top_reg;
      cnt_next   = cnt_reg;
      if (pop) begin
         top_next = ptr_dec(top_reg);
         cnt_next = cnt_reg - `RAP_PTR_W'(1);
      end
      if (ex_push_in && enabled && stack_enable_in) begin
         // Same-cycle pop and push: pop leaves, push replaces that slot
         top_next = pop ? top_reg : ptr_inc(top_reg);
         stack_next[top_next] = ex_ret_addr_in;
         if (!pop && cnt_reg != `RAP_PTR_W'(`RAP_DEPTH)) begin
            cnt_next = cnt_reg + `RAP_PTR_W'(1);
         end else if (pop) begin
            cnt_next = cnt_reg;
         end
      end
   end

   // Recovery tracking: one outstanding predicted return
   // A newer pop replaces the pending one; depth was traded for simplicity
   always_comb begin
      pend_next    = pend_reg;
      pred_next    = pred_reg;
      mispredict   = ex_ret_valid_in && pend_reg
                  && (!ex_cond_pass_in || ex_actual_addr_in != pred_reg);
      if (ex_ret_valid_in) begin
         pend_next = 1'b0;
      end
      if (pop) begin
         pend_next = 1'b1;
         pred_next = ret_target_out;
      end
      flush_next   = mispredict;
      refetch_next = mispredict ? (ex_cond_pass_in ? ex_actual_addr_in : ex_recovery_addr_in)
                                : refetch_reg;
   end

   // Stack registers; entries are cleared so the top read is never unknown
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < `RAP_DEPTH; i++) begin
            stack_reg[i] <= `RAP_ADDR_RESET;
         end
         top_reg <= `RAP_PTR_W'(0);
         cnt_reg <= `RAP_PTR_W'(0);
      end else begin
         stack_reg <= stack_next;
         top_reg   <= top_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Recovery registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pend_reg    <= 1'b0;
         pred_reg    <= `RAP_ADDR_RESET;
         flush_reg   <= 1'b0;
         refetch_reg <= `RAP_ADDR_RESET;
      end else begin
         pend_reg    <= pend_next;
         pred_reg    <= pred_next;
         flush_reg   <= flush_next;
         refetch_reg <= refetch_next;
      end
   end

   assign flush_out        = flush_reg;
   assign refetch_addr_out = refetch_reg;
   assign count_out        = cnt_reg;

   // Checks
   stack_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cnt_reg == `RAP_PTR_W'(0) |=> cnt_reg <= `RAP_PTR_W'(1))
      else $error("empty stack count wrapped");
   empty_nopred_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cnt_reg == `RAP_PTR_W'(0) |-> !ret_predict_out) else $error("prediction from empty stack");
   cond_ret_a: assert property (@(posedge clk_in) disable iff (rst_in)
      fetch_cond_in |-> !ret_predict_out) else $error("conditional return predicted");
   disabled_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !ctrl_in[`RAP_FLOW_EN_BIT] |-> !ret_predict_out && !call_predict_out)
      else $error("prediction while disabled");
   reg_call_a: assert property (@(posedge clk_in) disable iff (rst_in)
      fetch_kind_in == rap_pkg::RAP_KIND_CALL_XREG |-> !call_predict_out)
      else $error("register call predicted");
   pop_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ret_predict_out && !ex_push_in |=> cnt_reg == $past(cnt_reg) - `RAP_PTR_W'(1))
      else $error("pop did not decrement");
   push_target_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ex_push_in && enabled && stack_enable_in && !pop |=> ret_target_out == $past(ex_ret_addr_in))
      else $error("pushed address not on top");
   sequence ret_then_wrong_s;
      ret_predict_out ##1 (ex_ret_valid_in && ex_cond_pass_in && ex_actual_addr_in != pred_reg);
   endsequence
   wrong_flush_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ret_then_wrong_s |=> flush_out) else $error("wrong return not flushed");
   full_push_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ex_push_in && enabled && stack_enable_in && !pop && cnt_reg == `RAP_PTR_W'(`RAP_DEPTH)
      |=> cnt_reg == `RAP_PTR_W'(`RAP_DEPTH)) else $error("full push changed count");
   empty_push_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ex_push_in && enabled && stack_enable_in && !pop && cnt_reg == `RAP_PTR_W'(0)
      |=> cnt_reg == `RAP_PTR_W'(1)) else $error("push into empty stack miscounted");

   // Call direction: the static rule decides when the target cache misses
   uncond_call_a: assert property (@(posedge clk_in) disable iff (rst_in)
      call_predict_out && !fetch_cond_in |-> call_taken_out)
      else $error("unconditional call not taken");
   cond_call_a: assert property (@(posedge clk_in) disable iff (rst_in)
      call_predict_out && fetch_cond_in && !target_hit_in |-> !call_taken_out)
      else $error("conditional call taken on a miss");
   call_kind_a: assert property (@(posedge clk_in) disable iff (rst_in)
      enabled && fetch_valid_in && (fetch_kind_in == rap_pkg::RAP_KIND_CALL_IMM
      || fetch_kind_in == rap_pkg::RAP_KIND_CALL_XIMM) |-> call_predict_out)
      else $error("immediate call not predicted");

   // The multiple-load form is a return only with pc and writeback
   multi_ret_a: assert property (@(posedge clk_in) disable iff (rst_in)
      fetch_kind_in == rap_pkg::RAP_KIND_RET_MULTI && !fetch_pc_wb_in |-> !ret_predict_out)
      else $error("multiple load without pc predicted");

   // A disabled stack neither predicts nor moves its count
   stack_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !stack_enable_in |-> !ret_predict_out ##1 (cnt_reg == $past(cnt_reg)))
      else $error("disabled stack changed");

   // A pop steps the top pointer back by one slot
   pop_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ret_predict_out && !ex_push_in |=> top_reg == ptr_dec($past(top_reg)))
      else $error("pop did not step top pointer");

   // Recovery when the pending return fails its condition
   sequence cond_fail_s;
      pend_reg && ex_ret_valid_in && !ex_cond_pass_in;
   endsequence
   sequence recovery_load_s;
      flush_out && (refetch_addr_out == $past(ex_recovery_addr_in));
   endsequence
   cond_flush_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cond_fail_s |=> recovery_load_s) else $error("failed return not recovered");

   // Flush only follows a resolved pending return, and never a correct one
   flush_cause_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !(ex_ret_valid_in && pend_reg) |=> !flush_out) else $error("flush without a return");
   right_ret_a: assert property (@(posedge clk_in) disable iff (rst_in)
      pend_reg && ex_ret_valid_in && ex_cond_pass_in && ex_actual_addr_in == pred_reg
      |=> !flush_out) else $error("correct return flushed");
endmodule

//--- tb/rap_exec_model.sv
// Purpose: Execute-stage model that feeds pushes and return resolutions.
// Assumes: Bench raises one request at a time, on the rising edge.
// Notes:   Data lines carry inverted junk while no request is offered.
`timescale 1ns/1ps
module rap_exec_model (
   // Requests from the bench
   input  wire logic        push_req_in,
   input  wire logic        ret_req_in,
   input  wire logic        pass_in,
   input  wire logic [31:0] push_addr_in,
   input  wire logic [31:0] actual_in,
   input  wire logic [31:0] recov_in,
   // Execute-stage outputs
   output logic             ex_push_out,
   output logic             ex_rv_out,
   output logic             ex_pass_out,
   output logic [31:0]      ex_addr_out,
   output logic [31:0]      ex_act_out,
   output logic [31:0]      ex_rec_out
);
   // Junk when idle, so a design that samples late cannot read a stale value
   assign ex_push_out = push_req_in;
   assign ex_addr_out = push_req_in ? push_addr_in : ~push_addr_in;
   assign ex_rv_out   = ret_req_in;
   assign ex_pass_out = ret_req_in ? pass_in : ~pass_in;
   assign ex_act_out  = ret_req_in ? actual_in : ~actual_in;
   assign ex_rec_out  = ret_req_in ? recov_in : ~recov_in;
endmodule

//--- tb/tb_return_address_predictor.sv
// Purpose: Self-checking bench for the return address predictor.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes:   Combinational outputs are sampled 1 ns after the edge.
`timescale 1ns/1ps
`include "rap_regs.svh"
module tb_return_address_predictor;
   logic                   clk = 1'b0, rst = 1'b1, sen = 1'b1, fv = 1'b0, cnd = 1'b0, hit = 1'b0;
   logic [`RAP_CTRL_W-1:0] ctrl = `RAP_CTRL_RESET;
   rap_pkg::rap_kind_t     kind = rap_pkg::RAP_KIND_OTHER;
   logic [3:0]             rg = 4'h0;
   logic                   wb = 1'b1;
   logic                   preq = 1'b0, rreq = 1'b0, pass = 1'b0, xp, xv, xc, cp, ct, rp, fl;
   logic [31:0]            pa = 32'h0, act = 32'h0, rec = 32'h0, xa, xt, xr, rt, rf;
   logic [1:0]             cnt;
   int                     miscompares = 0, n_tests = 0;
   // Clock and execute-side partner
   always #2.5 clk = ~clk;
   rap_exec_model ex (.push_req_in(preq), .ret_req_in(rreq), .pass_in(pass), .push_addr_in(pa),
      .actual_in(act), .recov_in(rec), .ex_push_out(xp), .ex_rv_out(xv), .ex_pass_out(xc),
      .ex_addr_out(xa), .ex_act_out(xt), .ex_rec_out(xr));
   rap_return_predictor dut (.clk_in(clk), .rst_in(rst), .ctrl_in(ctrl), .stack_enable_in(sen),
      .fetch_valid_in(fv), .fetch_kind_in(kind), .fetch_reg_in(rg), .fetch_pc_wb_in(wb),
      .fetch_cond_in(cnd), .target_hit_in(hit), .ex_push_in(xp), .ex_ret_addr_in(xa),
      .ex_ret_valid_in(xv), .ex_cond_pass_in(xc), .ex_actual_addr_in(xt),
      .ex_recovery_addr_in(xr), .call_predict_out(cp), .call_taken_out(ct),
      .ret_predict_out(rp), .ret_target_out(rt), .flush_out(fl), .refetch_addr_out(rf),
      .count_out(cnt));
   // Comparison and closing
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Stimulus helpers
   task automatic push(input logic [31:0] a);
      @(posedge clk);
      preq <= 1'b1;
      pa   <= a;
      @(posedge clk);
      preq <= 1'b0;
      #1;
   endtask
   task automatic fetch(input rap_pkg::rap_kind_t k, input logic [3:0] r, input logic c,
                        input logic h, input logic e);
      @(posedge clk);
      fv   <= 1'b1;
      kind <= k;
      rg   <= r;
      cnd  <= c;
      hit  <= h;
      sen  <= e;
      #1;
   endtask
   task automatic idle;
      @(posedge clk);
      fv  <= 1'b0;
      sen <= 1'b1;
      wb  <= 1'b1;
      #1;
   endtask
   // Scenarios
   task automatic t_reset;
      chk("count", cnt, 32'h0);
      chk("refetch", rf, 32'h0);
      push(32'hA0);
      chk("count off", cnt, 32'h0);
      fetch(rap_pkg::RAP_KIND_RET_LINK, `RAP_LINK_REG, 1'b0, 1'b0, 1'b1);
      chk("ret off", rp, 32'h0);
      idle;
   endtask
   task automatic t_fill;
      rap_pkg::rap_kind_t rk[3] = '{rap_pkg::RAP_KIND_RET_LINK, rap_pkg::RAP_KIND_RET_MULTI,
                                    rap_pkg::RAP_KIND_RET_LDW};
      for (int i = 0; i < 4; i++) begin
         push(32'h1000 + 32'(i));
         chk("count up", cnt, (i < 2) ? i + 1 : 3);
      end
      for (int i = 0; i < 4; i++) begin
         fetch(rk[i % 3], `RAP_LINK_REG, 1'b0, 1'b0, 1'b1);
         chk("ret predict", rp, 32'(i < 3));
         if (i < 3) chk("ret target", rt, 32'h1003 - 32'(i));
         idle;
         chk("count down", cnt, (i < 3) ? 2 - i : 0);
      end
   endtask
   task automatic t_refuse;
      push(32'hB0);
      fetch(rap_pkg::RAP_KIND_RET_LINK, `RAP_LINK_REG, 1'b1, 1'b0, 1'b1);
      chk("cond ret", rp, 32'h0);
      fetch(rap_pkg::RAP_KIND_RET_LINK, 4'h3, 1'b0, 1'b0, 1'b1);
      chk("other reg", rp, 32'h0);
      @(posedge clk);
      kind <= rap_pkg::RAP_KIND_RET_MULTI;
      wb   <= 1'b0;
      #1;
      chk("no writeback", rp, 32'h0);
      fetch(rap_pkg::RAP_KIND_RET_LINK, `RAP_LINK_REG, 1'b0, 1'b0, 1'b0);
      chk("stack off", rp, 32'h0);
      idle;
      chk("count kept", cnt, 32'h1);
      fetch(rap_pkg::RAP_KIND_RET_LINK, `RAP_LINK_REG, 1'b0, 1'b0, 1'b1);
      chk("ret after refusals", rp, 32'h1);
      chk("target after refusals", rt, 32'hB0);
      idle;
      chk("count popped", cnt, 32'h0);
   endtask
   task automatic t_calls;
      rap_pkg::rap_kind_t ck[3] = '{rap_pkg::RAP_KIND_CALL_IMM, rap_pkg::RAP_KIND_CALL_XIMM,
                                    rap_pkg::RAP_KIND_CALL_XREG};
      for (int i = 0; i < 12; i++) begin
         fetch(ck[i / 4], 4'h0, i[0], i[1], 1'b1);
         chk("call predict", cp, 32'(i < 8));
         chk("call taken", ct, 32'(i < 8 && (i[1] || !i[0])));
      end
      idle;
      chk("count calls", cnt, 32'h0);
   endtask
   task automatic t_mispredict;
      for (int j = 0; j < 3; j++) begin
         push(32'hC0);
         fetch(rap_pkg::RAP_KIND_RET_LINK, `RAP_LINK_REG, 1'b0, 1'b0, 1'b1);
         @(posedge clk);
         fv   <= 1'b0;
         rreq <= 1'b1;
         pass <= (j != 1);
         act  <= (j == 2) ? 32'hC0 : 32'hD0;
         rec  <= 32'hE0;
         @(posedge clk);
         rreq <= 1'b0;
         #1;
         chk("flush", fl, 32'(j != 2));
         if (j != 2) chk("refetch", rf, (j == 0) ? 32'hD0 : 32'hE0);
         @(posedge clk);
         #1;
         chk("flush end", fl, 32'h0);
      end
   endtask
   // Main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_reset;
      @(posedge clk);
      ctrl[`RAP_FLOW_EN_BIT] <= 1'b1;
      t_fill;
      t_refuse;
      t_calls;
      t_mispredict;
      stop_test;
   end
   initial begin
      repeat (2000) @(posedge clk);
      miscompares++;
      stop_test;
   end
endmodule
